// ---- pll2_divider_and_lock_mux.sv ----
// Contract
// - Frequency field 8 bits, 1..250 valid
// - 12-bit reference divider feeds phase detector
// - Selector codes 0,1,2: HiZ, high, low
// - Codes 3-7: digital and analog lock
// - Codes 9,11,20,22: divider outputs halved
// - Codes 14,15,23,24: loop-one and combined lock
// - Selector programmed over serial interface
// - 18-bit feedback divider feeds phase detector
// - Feedback divider write starts VCO tuning
// - Gain code picks current; high-Z overrides
// - VCO divider ratios 2 to 8
// - VCO divider drives distribution and feedback
// - High-Z bit one floats pump output
`timescale 1ns/1ps
`default_nettype none
module pll2_divider_and_lock_mux (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Three-wire serial programming pins
    input wire logic serialClock,
    input wire logic serialData,
    input wire logic serialLatch,
    // Clock events, one-cycle pulses from same-clock logic
    input wire logic referenceTick,
    input wire logic vcoTick,
    input wire logic pll1FeedbackTick,
    input wire logic pll1ReferenceTick,
    // Lock indications, same-clock levels
    input wire logic pll2DigitalLock,
    input wire logic pll2AnalogLock,
    input wire logic pll1DigitalLock,
    // Lock detect pin
    output logic lockPinOut,
    output logic lockPinOeN,
    // Phase detector and distribution
    output logic phaseRefPulse,
    output logic phaseFbPulse,
    output logic distributionTick,
    // Charge pump and tuning
    output logic [1:0] pumpCurrentSelect,
    output logic pumpHighZ,
    output logic vcoTuneStart,
    output logic [7:0] refFreqMhz,
    output logic refFreqValid
);
    // Whole block state in one packed record
    typedef struct packed {
        // Pin synchronisers, third stage only for edges
        logic [2:0] sckSync;
        logic [1:0] sdaSync;
        logic [2:0] leSync;
        // Serial shift register, newest bit at the bottom
        logic [31:0] shift;
        // Programmed fields, changed only on latch
        logic [7:0] freq;
        logic [11:0] rDiv;
        logic [4:0] sel;
        logic [17:0] nDiv;
        logic [1:0] gain;
        logic [3:0] vDiv;
        logic hiZ;
        // Divider counters
        logic [11:0] rCnt;
        logic [3:0] vCnt;
        logic [17:0] nCnt;
        // Divider output pulses, one cycle each
        logic rPulse;
        logic nPulse;
        logic vPulse;
        // Halved divider outputs for the lock pin
        logic rHalf;
        logic nHalf;
        logic r1Half;
        logic n1Half;
        // Tuning request pulse
        logic tune;
        // Lock pin drive, registered to avoid glitches
        logic pinOut;
        logic pinOeN;
    } state_s;

    state_s st;
    state_s next_st;

    logic sckRise;
    logic leRise;
    logic [3:0] addr;
    logic [3:0] vRatio;

    // Edges seen only on the second sync stage and its delayed copy
    assign sckRise = st.sckSync[1] & ~st.sckSync[2];
    assign leRise = st.leSync[1] & ~st.leSync[2];
    assign addr = st.shift[3:0];

    // Out-of-range VCO ratios fall back to the nearest legal one
    // Invalid codes are stored as written; only the count is clamped
    // Keeps the divider running rather than stalling the outputs
    always_comb begin
        if (st.vDiv < pll2_cfg_pkg::VDIV_MIN) begin
            vRatio = pll2_cfg_pkg::VDIV_MIN;
        end else if (st.vDiv > pll2_cfg_pkg::VDIV_MAX) begin
            vRatio = pll2_cfg_pkg::VDIV_MAX;
        end else begin
            vRatio = st.vDiv;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;
        next_st.sckSync = {st.sckSync[1:0], serialClock};
        next_st.sdaSync = {st.sdaSync[0], serialData};
        next_st.leSync = {st.leSync[1:0], serialLatch};
        next_st.tune = 1'b0;
        next_st.rPulse = 1'b0;
        next_st.nPulse = 1'b0;
        next_st.vPulse = 1'b0;

        // Shift register only; fields untouched until latch
        if (sckRise) begin
            next_st.shift = {st.shift[30:0], st.sdaSync[1]};
        end

        // Completed word is applied in one step on latch rise
        // Unknown addresses fall through and are ignored
        // Latch mid-word would apply a partial word; host must not
        if (leRise) begin
            if (addr == pll2_cfg_pkg::ADDR_PUMP_CTRL) begin
                next_st.hiZ = st.shift[pll2_cfg_pkg::PUMP_HIZ_POS];
            end else if (addr == pll2_cfg_pkg::ADDR_REF_LOCK) begin
                next_st.freq = st.shift[pll2_cfg_pkg::FREQ_LSB +: 8];
                next_st.sel = st.shift[pll2_cfg_pkg::SEL_LSB +: 5];
                next_st.rDiv = st.shift[pll2_cfg_pkg::RDIV_LSB +: 12];
            end else if (addr == pll2_cfg_pkg::ADDR_FEEDBACK) begin
                next_st.gain = st.shift[pll2_cfg_pkg::GAIN_LSB +: 2];
                next_st.vDiv = st.shift[pll2_cfg_pkg::VDIV_LSB +: 4];
                next_st.nDiv = st.shift[pll2_cfg_pkg::NDIV_LSB +: 18];
                next_st.tune = 1'b1;
            end
        end

        // Reference divider; a zero ratio stops its output
        // Compare with >= so a smaller new ratio never overruns
        if (referenceTick && st.rDiv != 12'h000) begin
            if (st.rCnt >= st.rDiv - 12'h001) begin
                next_st.rCnt = 12'h000;
                next_st.rPulse = 1'b1;
                next_st.rHalf = ~st.rHalf;
            end else begin
                next_st.rCnt = st.rCnt + 12'h001;
            end
        end

        // VCO output divider feeding distribution and feedback
        if (vcoTick) begin
            if (st.vCnt >= vRatio - 4'h1) begin
                next_st.vCnt = 4'h0;
                next_st.vPulse = 1'b1;
            end else begin
                next_st.vCnt = st.vCnt + 4'h1;
            end
        end

        // Feedback divider counts VCO divider output
        // Uses the registered pulse, so one cycle behind distribution
        if (st.vPulse && st.nDiv != 18'h00000) begin
            if (st.nCnt >= st.nDiv - 18'h00001) begin
                next_st.nCnt = 18'h00000;
                next_st.nPulse = 1'b1;
                next_st.nHalf = ~st.nHalf;
            end else begin
                next_st.nCnt = st.nCnt + 18'h00001;
            end
        end

        // Loop-one divider outputs are halved here too
        if (pll1FeedbackTick) begin
            next_st.n1Half = ~st.n1Half;
        end
        if (pll1ReferenceTick) begin
            next_st.r1Half = ~st.r1Half;
        end

        // Lock pin source; reserved codes float the pin
        next_st.pinOut = 1'b0;
        next_st.pinOeN = 1'b0;
        // Output value low while floating, except pull-up-only code 7, which holds it high
        case (st.sel)
            pll2_cfg_pkg::SEL_HIZ: begin
                next_st.pinOeN = 1'b1;
            end
            pll2_cfg_pkg::SEL_HIGH: begin
                next_st.pinOut = 1'b1;
            end
            pll2_cfg_pkg::SEL_LOW: begin
                next_st.pinOut = 1'b0;
            end
            // Loop-two lock levels
            pll2_cfg_pkg::SEL_DLD2_HI: begin
                next_st.pinOut = pll2DigitalLock;
            end
            pll2_cfg_pkg::SEL_DLD2_LO: begin
                next_st.pinOut = ~pll2DigitalLock;
            end
            pll2_cfg_pkg::SEL_ALD2_PP: begin
                next_st.pinOut = pll2AnalogLock;
            end
            pll2_cfg_pkg::SEL_ALD2_NOD: begin
                // Pull-down only; released when locked
                next_st.pinOut = 1'b0;
                next_st.pinOeN = pll2AnalogLock;
            end
            pll2_cfg_pkg::SEL_ALD2_POD: begin
                // Pull-up only; released when unlocked
                next_st.pinOut = 1'b1;
                next_st.pinOeN = ~pll2AnalogLock;
            end
            // Halved divider outputs, square wave at half rate
            pll2_cfg_pkg::SEL_N2_HALF: begin
                next_st.pinOut = st.nHalf;
            end
            pll2_cfg_pkg::SEL_R2_HALF: begin
                next_st.pinOut = st.rHalf;
            end
            pll2_cfg_pkg::SEL_N1_HALF: begin
                next_st.pinOut = st.n1Half;
            end
            pll2_cfg_pkg::SEL_R1_HALF: begin
                next_st.pinOut = st.r1Half;
            end
            // Loop-one and combined lock levels
            pll2_cfg_pkg::SEL_DLD1_HI: begin
                next_st.pinOut = pll1DigitalLock;
            end
            pll2_cfg_pkg::SEL_DLD1_LO: begin
                next_st.pinOut = ~pll1DigitalLock;
            end
            pll2_cfg_pkg::SEL_BOTH: begin
                next_st.pinOut = pll1DigitalLock & pll2DigitalLock;
            end
            pll2_cfg_pkg::SEL_BOTH_INV: begin
                next_st.pinOut = ~(pll1DigitalLock & pll2DigitalLock);
            end
            // Reserved codes float, the safest pin state
            default: begin
                next_st.pinOeN = 1'b1;
            end
        endcase
    end

    // State register; constants only under reset
    // Pin floats during reset so a shared lock line is not forced
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.freq <= pll2_cfg_pkg::FREQ_RST;
            st.rDiv <= pll2_cfg_pkg::RDIV_RST;
            st.sel <= pll2_cfg_pkg::SEL_RST;
            st.nDiv <= pll2_cfg_pkg::NDIV_RST;
            st.gain <= pll2_cfg_pkg::GAIN_RST;
            st.vDiv <= pll2_cfg_pkg::VDIV_RST;
            st.hiZ <= pll2_cfg_pkg::HIZ_RST;
            st.pinOeN <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    // Only the frequency check is decoded, from a stored field
    assign lockPinOut = st.pinOut;
    assign lockPinOeN = st.pinOeN;
    assign phaseRefPulse = st.rPulse;
    assign phaseFbPulse = st.nPulse;
    assign distributionTick = st.vPulse;
    assign pumpCurrentSelect = st.gain;
    assign pumpHighZ = st.hiZ;
    assign vcoTuneStart = st.tune;
    assign refFreqMhz = st.freq;
    // Valid only for 1..250 MHz
    assign refFreqValid = (st.freq != 8'h00) &&
        (st.freq <= pll2_cfg_pkg::FREQ_MAX);
endmodule
`default_nettype wire

// ---- pll2_cfg_pkg.sv ----
package pll2_cfg_pkg;
    // Serial word: 28 data bits above a 4-bit register address
    localparam int WORD_BITS = 32;
    localparam int ADDR_BITS = 4;
    localparam logic [3:0] ADDR_PUMP_CTRL = 4'hD;
    localparam logic [3:0] ADDR_REF_LOCK = 4'hE;
    localparam logic [3:0] ADDR_FEEDBACK = 4'hF;

    // Field positions inside the 32-bit word
    localparam int PUMP_HIZ_POS = 4;
    localparam int FREQ_LSB = 24;
    localparam int SEL_LSB = 16;
    localparam int RDIV_LSB = 4;
    localparam int GAIN_LSB = 30;
    localparam int VDIV_LSB = 26;
    localparam int NDIV_LSB = 8;

    // Field widths
    localparam int FREQ_W = 8;
    localparam int RDIV_W = 12;
    localparam int SEL_W = 5;
    localparam int NDIV_W = 18;
    localparam int GAIN_W = 2;
    localparam int VDIV_W = 4;

    // Reset values
    localparam logic [7:0] FREQ_RST = 8'h0A;
    localparam logic [11:0] RDIV_RST = 12'h001;
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [17:0] NDIV_RST = 18'h00001;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [3:0] VDIV_RST = 4'h2;
    localparam logic HIZ_RST = 1'b0;

    // Legal limits
    localparam logic [7:0] FREQ_MAX = 8'hFA;
    localparam logic [3:0] VDIV_MIN = 4'h2;
    localparam logic [3:0] VDIV_MAX = 4'h8;

    // Lock pin source codes
    typedef enum logic [4:0] {
        SEL_HIZ = 5'b00000,
        SEL_HIGH = 5'b00001,
        SEL_LOW = 5'b00010,
        SEL_DLD2_HI = 5'b00011,
        SEL_DLD2_LO = 5'b00100,
        SEL_ALD2_PP = 5'b00101,
        SEL_ALD2_NOD = 5'b00110,
        SEL_ALD2_POD = 5'b00111,
        SEL_N2_HALF = 5'b01001,
        SEL_R2_HALF = 5'b01011,
        SEL_DLD1_HI = 5'b01110,
        SEL_DLD1_LO = 5'b01111,
        SEL_N1_HALF = 5'b10100,
        SEL_R1_HALF = 5'b10110,
        SEL_BOTH = 5'b10111,
        SEL_BOTH_INV = 5'b11000
    } lock_sel_e;
endpackage

// ---- pll2_cfg_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll2_cfg_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Stimulus seen at the pins
    input wire logic serialLatch,
    input wire logic referenceTick,
    input wire logic vcoTick,
    // Observed outputs
    input wire logic phaseRefPulse,
    input wire logic phaseFbPulse,
    input wire logic distributionTick,
    input wire logic [1:0] pumpCurrentSelect,
    input wire logic pumpHighZ,
    input wire logic vcoTuneStart,
    input wire logic [7:0] refFreqMhz,
    input wire logic refFreqValid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_freqValid;
        refFreqValid == (refFreqMhz != 8'h00 && refFreqMhz <= 8'hFA);
    endproperty
    a_freqValid: assert property (p_freqValid)
        else $error("frequency valid flag wrong");
    property p_refPulse;
        phaseRefPulse |-> $past(referenceTick);
    endproperty
    a_refPulse: assert property (p_refPulse)
        else $error("reference pulse without tick");
    property p_distPulse;
        distributionTick |-> $past(vcoTick);
    endproperty
    a_distPulse: assert property (p_distPulse)
        else $error("distribution tick without vco tick");
    property p_fbPulse;
        phaseFbPulse |-> $past(distributionTick);
    endproperty
    a_fbPulse: assert property (p_fbPulse)
        else $error("feedback pulse without distribution tick");
    // Ratio is never below two, so no back-to-back ticks
    property p_distGap;
        distributionTick |=> !distributionTick;
    endproperty
    a_distGap: assert property (p_distGap)
        else $error("distribution ticks adjacent");
    property p_gainHold;
        !$stable(pumpCurrentSelect) |-> $past(serialLatch, 3) ||
            $past(serialLatch, 4);
    endproperty
    a_gainHold: assert property (p_gainHold)
        else $error("gain changed outside a latch");
    property p_hizHold;
        !$stable(pumpHighZ) |-> $past(serialLatch, 3) ||
            $past(serialLatch, 4);
    endproperty
    a_hizHold: assert property (p_hizHold)
        else $error("high-Z bit changed outside a latch");
    property p_tuneCause;
        vcoTuneStart |-> $past(serialLatch, 3) || $past(serialLatch, 4);
    endproperty
    a_tuneCause: assert property (p_tuneCause)
        else $error("tuning started without a write");
endmodule
`default_nettype wire

// ---- pll2_serial_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll2_serial_host (
    // Clock
    input wire logic clock,
    // Programming pins
    output logic serialClock,
    output logic serialData,
    output logic serialLatch
);
    // Idle: clock parked low between frames
    initial begin
        serialClock = 1'b0;
        serialData = 1'b0;
        serialLatch = 1'b0;
    end
    // MSB first, four clocks per phase for synchroniser margin
    task automatic send(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            @(negedge clock);
            serialData = word[i];
            repeat (4) @(negedge clock);
            serialClock = 1'b1;
            repeat (4) @(negedge clock);
            serialClock = 1'b0;
        end
        repeat (4) @(negedge clock);
        serialLatch = 1'b1;
        repeat (4) @(negedge clock);
        serialLatch = 1'b0;
        serialData = ~serialData; // Inverted from the last bit, not released
    endtask
endmodule
`default_nettype wire

// ---- tb_pll2_divider_and_lock_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pll2_divider_and_lock_mux;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic serialClock, serialData, serialLatch;
    logic referenceTick = 1'b0;
    logic vcoTick = 1'b0;
    logic pll1FeedbackTick = 1'b0;
    logic pll1ReferenceTick = 1'b0;
    logic pll2DigitalLock = 1'b0;
    logic pll2AnalogLock = 1'b0;
    logic pll1DigitalLock = 1'b0;
    logic lockPinOut, lockPinOeN, phaseRefPulse, phaseFbPulse;
    logic distributionTick, pumpHighZ, vcoTuneStart, refFreqValid;
    logic [1:0] pumpCurrentSelect, e;
    logic [7:0] refFreqMhz, f;
    logic [4:0] codes [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 14, 15, 23, 24};
    logic [1:0] gainQ [$];
    int miscompares = 0, n_checks = 0, seed = 65;
    int nRef = 0, nDist = 0, nFb = 0;
    pll2_divider_and_lock_mux uut (.*);
    pll2_serial_host host (.*);
    always #20 clock = ~clock;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Expected {oeN, out}; out reads 0 whenever the pin floats
    function automatic logic [1:0] lockExp(input logic [4:0] s,
        input logic d2, input logic a2, input logic d1);
        case (s)
            5'h01: return 2'b01;
            5'h02: return 2'b00;
            5'h03: return {1'b0, d2};
            5'h04: return {1'b0, !d2};
            5'h05: return {1'b0, a2};
            5'h06: return {a2, 1'b0};
            5'h07: return {!a2, a2};
            5'h0E: return {1'b0, d1};
            5'h0F: return {1'b0, !d1};
            5'h17: return {1'b0, d1 & d2};
            5'h18: return {1'b0, !(d1 & d2)};
            default: return 2'b10;
        endcase
    endfunction
    // Each tuning pulse pairs with the oldest pending feedback write
    // Sampled on the falling edge, clear of the launching edge
    always @(negedge clock) begin
        if (nrst && vcoTuneStart === 1'b1) begin
            if (gainQ.size() == 0) check(8'h01, 8'h00);
            else check(8'(pumpCurrentSelect), 8'(gainQ.pop_front()));
        end
        if (phaseRefPulse === 1'b1) nRef++;
        if (distributionTick === 1'b1) nDist++;
        if (phaseFbPulse === 1'b1) nFb++;
    end
    // Hang guard, far beyond the expected run
    initial begin
        #1000000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        check(refFreqMhz, pll2_cfg_pkg::FREQ_RST);
        check(8'(lockPinOeN), 8'h01);
        repeat (3) @(negedge clock);
        // Every gain code, VCO ratio 5, feedback ratio 2
        for (int g = 0; g < 4; g++) begin
            gainQ.push_back(2'(g));
            host.send({2'(g), 4'h5, 18'h00002, 4'h0,
                pll2_cfg_pkg::ADDR_FEEDBACK});
            repeat (8) @(negedge clock);
        end
        check(8'(gainQ.size()), 8'h00);
        // High-Z overrides without touching the gain
        for (int h = 1; h >= 0; h--) begin
            host.send({27'h0, 1'(h), pll2_cfg_pkg::ADDR_PUMP_CTRL});
            repeat (8) @(negedge clock);
            check(8'(pumpHighZ), 8'(h));
            check(8'(pumpCurrentSelect), 8'h03);
        end
        // Selector codes with random lock levels and frequency bounds
        for (int i = 0; i < 13; i++) begin
            f = 8'($random(seed));
            if (i < 3) f = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFA : 8'hFB);
            pll2DigitalLock = 1'($random(seed));
            pll2AnalogLock = 1'($random(seed));
            pll1DigitalLock = 1'($random(seed));
            host.send({f, 3'h0, codes[i], 12'h003,
                pll2_cfg_pkg::ADDR_REF_LOCK});
            repeat (4) @(negedge clock);
            e = lockExp(codes[i], pll2DigitalLock, pll2AnalogLock,
                pll1DigitalLock);
            check({6'h0, lockPinOeN, !lockPinOeN & lockPinOut},
                {6'h0, e});
            check(8'(refFreqValid), 8'(f != 8'h00 && f <= 8'hFA));
        end
        // Loop-one halved outputs: one tick flips the pin
        for (int k = 0; k < 2; k++) begin
            host.send({8'h0A, 3'h0, (k == 0) ? 5'h14 : 5'h16, 12'h003,
                pll2_cfg_pkg::ADDR_REF_LOCK});
            repeat (4) @(negedge clock);
            e = {1'b0, lockPinOut};
            pll1FeedbackTick = (k == 0);
            pll1ReferenceTick = (k == 1);
            @(negedge clock);
            pll1FeedbackTick = 1'b0;
            pll1ReferenceTick = 1'b0;
            repeat (3) @(negedge clock);
            check({7'h0, lockPinOut}, {7'h0, !e[0]});
        end
        // Ticks every clock: R=3, VCO ratio 5, feedback 2
        nRef = 0;
        nDist = 0;
        nFb = 0;
        referenceTick = 1'b1;
        vcoTick = 1'b1;
        repeat (30) @(negedge clock);
        referenceTick = 1'b0;
        vcoTick = 1'b0;
        repeat (3) @(negedge clock);
        check(8'(nRef), 8'd10);
        check(8'(nDist), 8'd6);
        check(8'(nFb), 8'd3);
        wrap_up();
    end
endmodule
bind pll2_divider_and_lock_mux pll2_cfg_checker chk (.*);
`default_nettype wire
